// ---- logic/ptpc_params.svh ----
/*
 Register offsets, reset values and widths of the pin control block.
 Assumes inclusion by bare name from the design files.
*/
`ifndef PTPC_PARAMS_SVH
`define PTPC_PARAMS_SVH
`define PTPC_IDX_DATA    8'h00
`define PTPC_IDX_INPUT   8'h01
`define PTPC_IDX_DIR     8'h02
`define PTPC_IDX_DRIVE   8'h03
`define PTPC_IDX_PULLEN  8'h04
`define PTPC_IDX_PULLPOL 8'h05
`define PTPC_IDX_ROUTE   8'h07
`define PTPC_IDX_TIMCTL  8'h08
`define PTPC_RST_BYTE    8'h00
`define PTPC_RST_ROUTE   5'h00
`define PTPC_ROUTE_W     5
`define PTPC_SYNC_STAGES 2
`endif

// ---- logic/ptpc_pkg.sv ----
/*
 Types shared by the pin control block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ptpc_pkg;
	typedef logic [7:0] ptpc_byte_t;
	typedef enum logic [1:0] {
		ptpc_src_gpio  = 2'b00,
		ptpc_src_timer = 2'b01,
		ptpc_src_pwm   = 2'b10
	} ptpc_src_e;
endpackage

// ---- logic/ptpc_sync.sv ----
/*
 Two-flop synchroniser for a bus of pin levels.
 Assumes the inputs are asynchronous to pclk.
*/
`include "ptpc_params.svh"
module ptpc_sync
	import ptpc_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	// Refused while elaborating, so a bad width never reaches silicon
	if (WIDTH < 1) begin : g_bad_width
		$error("ptpc_sync: WIDTH must be positive");
	end

	// First stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

// ---- logic/ptpc_out_mux.sv ----
/*
 Per-pin output source and direction selection.
 Assumes timer and PWM qualifiers arrive on pclk.
*/
`include "ptpc_params.svh"
module ptpc_out_mux
	import ptpc_pkg::*;
#(
	parameter int PINS   = 8,
	parameter int ROUTED = 5
) (
	input  wire logic [PINS-1:0]   gpio_data,
	input  wire logic [PINS-1:0]   gpio_dir,
	input  wire logic [ROUTED-1:0] output_route_select,
	input  wire logic [ROUTED-1:0] pwm_channel_enable,
	input  wire logic [ROUTED-1:0] pwm_out,
	input  wire logic [PINS-1:0]   timer_output_active,
	input  wire logic [PINS-1:0]   timer_out,
	output logic      [PINS-1:0]   pin_value,
	output logic      [PINS-1:0]   pin_is_output
);
	if (ROUTED > PINS) begin : g_bad_routed
		$error("ptpc_out_mux: ROUTED exceeds PINS");
	end

	genvar i;
	generate
		for (i = 0; i < PINS; i++) begin : g_pin
			wire use_pwm;
			wire use_tim;
			if (i < ROUTED) begin : g_routed
				// Routing bit 1 selects PWM, 0 the timer
				assign use_pwm = output_route_select[i] &
					pwm_channel_enable[i];
				assign use_tim = ~use_pwm &
					timer_output_active[i];
			end else begin : g_plain
				assign use_pwm = 1'b0;
				assign use_tim = timer_output_active[i];
			end
			// Peripheral forces output, stored bit untouched
			assign pin_is_output[i] = use_pwm | use_tim |
				gpio_dir[i];
			assign pin_value[i] = use_pwm ? pwm_out[i < ROUTED ? i : 0] :
				use_tim ? timer_out[i] : gpio_data[i];
		end
	endgenerate
endmodule

// ---- logic/ptpc_top.sv ----
/*
 Port pin control for one 8-bit port, APB slave, single pclk domain.
 Assumes the pad ring resolves pin level from output enable, pull and
 drive controls, and that timer and PWM signals are on pclk.
*/
`include "ptpc_params.svh"
// Notes on behaviour
// - Pull polarity picks interrupt edge elsewhere
// - Pull polarity 0 up, 1 down
// - This port has no pin interrupts
// - Output pins never get a pull
// - Pull enable 1 enables, 0 disables
// - Pull enables clear after reset
// - Reduced drive bit gives third strength
// - Reduced drive ignored on inputs
// - Data read: register if direction bit set, else pin
// - Input register always returns synced pins
// - Input register writes are discarded
// - Reads settle within two cycles
// - Timer output channel owns its pin unless routed PWM takes it
// - Takeover forces output, direction bits kept
// - Disabled compare returns direction control
// - Timer capture always sees pin level
// - Priority PWM, then timer, then GPIO
// - Timer active needs enable, mode, routing
// - Control registers accessible at any time
// - Reads are synchronous to pclk
// - Route bit 0 timer, 1 PWM
module ptpc_top
	import ptpc_pkg::*;
#(
	parameter int PINS   = 8,
	parameter int ROUTED = `PTPC_ROUTE_W
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [PINS-1:0]   pin_in,
	output logic      [PINS-1:0]   pin_out,
	output logic      [PINS-1:0]   pin_oe_n,
	output logic      [PINS-1:0]   pin_reduced_drive,
	output logic      [PINS-1:0]   pin_pull_up,
	output logic      [PINS-1:0]   pin_pull_down,
	input  wire logic              timer_global_enable,
	input  wire logic [PINS-1:0]   timer_compare_select,
	input  wire logic [PINS-1:0]   timer_overflow_toggle,
	input  wire logic [PINS-1:0]   timer_action_routed,
	input  wire logic [PINS-1:0]   timer_out,
	output logic      [PINS-1:0]   timer_capture_in,
	input  wire logic [ROUTED-1:0] pwm_channel_enable,
	input  wire logic [ROUTED-1:0] pwm_out
);
	if (PINS != 8) begin : g_bad_pins
		$error("ptpc_top: register map serves eight pins only");
	end
	if (ROUTED < 1 || ROUTED > PINS) begin : g_bad_routed
		$error("ptpc_top: ROUTED out of range");
	end

	ptpc_byte_t        port_data_reg;
	ptpc_byte_t        port_direction_reg;
	ptpc_byte_t        port_drive_reduce_reg;
	ptpc_byte_t        port_pull_enable_reg;
	ptpc_byte_t        port_pull_polarity_reg;
	logic [ROUTED-1:0] output_route_select;
	logic [PINS-1:0]   pin_sync;
	logic [PINS-1:0]   timer_output_active;
	logic [PINS-1:0]   pin_is_output;
	logic [PINS-1:0]   pin_value;
	logic [31:0]       next_prdata;

	// Pins are asynchronous, so two flops before any read
	ptpc_sync #(
		.WIDTH    (PINS)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (pin_in),
		.sync_out (pin_sync)
	);

	// Bus decode; word index is the register's printed offset
	wire [9:0] reg_index  = paddr[11:2];
	wire       bus_access = psel & penable;
	wire       bus_write  = bus_access & pwrite;
	wire       bus_read   = bus_access & ~pwrite;
	wire       hit_data   = reg_index == 10'(`PTPC_IDX_DATA);
	wire       hit_input  = reg_index == 10'(`PTPC_IDX_INPUT);
	wire       hit_dir    = reg_index == 10'(`PTPC_IDX_DIR);
	wire       hit_drive  = reg_index == 10'(`PTPC_IDX_DRIVE);
	wire       hit_pullen = reg_index == 10'(`PTPC_IDX_PULLEN);
	wire       hit_pullpol = reg_index == 10'(`PTPC_IDX_PULLPOL);
	wire       hit_route  = reg_index == 10'(`PTPC_IDX_ROUTE);
	wire       hit_any    = hit_data | hit_input | hit_dir | hit_drive |
		hit_pullen | hit_pullpol | hit_route;
	wire [7:0] wbyte      = pwdata[7:0];

	// Zero wait states keep read timing fixed at one access cycle
	assign pready  = 1'b1;
	assign pslverr = bus_access & ~hit_any;

	// Control registers writable in any mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_data_reg          <= `PTPC_RST_BYTE;
			port_direction_reg     <= `PTPC_RST_BYTE;
			port_drive_reduce_reg  <= `PTPC_RST_BYTE;
			port_pull_enable_reg   <= `PTPC_RST_BYTE;
			port_pull_polarity_reg <= `PTPC_RST_BYTE;
			output_route_select    <= ROUTED'(`PTPC_RST_ROUTE);
		end else begin
			if (bus_write && hit_data)
				port_data_reg <= wbyte;
			if (bus_write && hit_dir)
				port_direction_reg <= wbyte;
			if (bus_write && hit_drive)
				port_drive_reduce_reg <= wbyte;
			if (bus_write && hit_pullen)
				port_pull_enable_reg <= wbyte;
			if (bus_write && hit_pullpol)
				port_pull_polarity_reg <= wbyte;
			// Bit 4 stored as written; keeping it clear is software's job
			if (bus_write && hit_route)
				output_route_select <= wbyte[ROUTED-1:0];
		end
	end
	// Input register has no write path at all

	// Timer qualifier: global enable, compare or toggle mode, routed
	assign timer_output_active = {PINS{timer_global_enable}} &
		(timer_compare_select | timer_overflow_toggle) &
		timer_action_routed;

	ptpc_out_mux #(
		.PINS                (PINS),
		.ROUTED              (ROUTED)
	) u_mux (
		.gpio_data           (port_data_reg),
		.gpio_dir            (port_direction_reg),
		.output_route_select (output_route_select),
		.pwm_channel_enable  (pwm_channel_enable),
		.pwm_out             (pwm_out),
		.timer_output_active (timer_output_active),
		.timer_out           (timer_out),
		.pin_value           (pin_value),
		.pin_is_output       (pin_is_output)
	);

	// Pad controls registered so the pins see clean levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out           <= '0;
			pin_oe_n          <= '1;
			pin_reduced_drive <= '0;
			pin_pull_up       <= '0;
			pin_pull_down     <= '0;
		end else begin
			pin_out           <= pin_value;
			pin_oe_n          <= ~pin_is_output;
			pin_reduced_drive <= port_drive_reduce_reg &
				pin_is_output;
			pin_pull_up       <= port_pull_enable_reg & ~pin_is_output &
				~port_pull_polarity_reg;
			pin_pull_down     <= port_pull_enable_reg & ~pin_is_output &
				port_pull_polarity_reg;
		end
	end

	// Capture path follows the pin whatever drives it
	assign timer_capture_in = pin_sync;

	// No edge detector here: this port carries no pin interrupt
	// Polarity bits only steer pulls on this port

	// Read mux; synchronised pin data may lag a direction change
	always_comb begin
		next_prdata = 32'h0000_0000;
		if (hit_data)
			next_prdata[7:0] = (port_direction_reg & port_data_reg) |
				(~port_direction_reg & pin_sync);
		else if (hit_input)
			next_prdata[7:0] = pin_sync;
		else if (hit_dir)
			next_prdata[7:0] = port_direction_reg;
		else if (hit_drive)
			next_prdata[7:0] = port_drive_reduce_reg;
		else if (hit_pullen)
			next_prdata[7:0] = port_pull_enable_reg;
		else if (hit_pullpol)
			next_prdata[7:0] = port_pull_polarity_reg;
		else if (hit_route)
			next_prdata[ROUTED-1:0] = output_route_select;
	end

	// Read data registered in the setup cycle, valid in access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= next_prdata;
		else if (bus_read)
			prdata <= prdata;
	end
endmodule

// ---- sim/ptpc_pin_model.sv ----
/*
 Pad and board model for the eight port pins.
 Assumes ext is what the board drives on a pin nobody else drives.
*/
module ptpc_pin_model (
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe_n,
	input  wire logic [7:0] pin_pull_up,
	input  wire logic [7:0] pin_pull_down,
	input  wire logic [7:0] ext,
	input  wire logic [7:0] short_low,
	output logic      [7:0] pin_in
);
	// Pulls beat the board, so a pulled pin shows the pull level
	assign pin_in = ~short_low & (~pin_oe_n & pin_out
		| pin_oe_n & (pin_pull_up | ~pin_pull_down & ext));
endmodule

// ---- sim/ptpc_top_sva.sv ----
/*
 Port-level checker of the pin control block.
 Assumes one pclk domain and presetn low active.
*/
module ptpc_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic [7:0]  pin_in,
	input wire logic [7:0]  pin_out,
	input wire logic [7:0]  pin_oe_n,
	input wire logic [7:0]  pin_reduced_drive,
	input wire logic [7:0]  pin_pull_up,
	input wire logic [7:0]  pin_pull_down,
	input wire logic        timer_global_enable,
	input wire logic [7:0]  timer_compare_select,
	input wire logic [7:0]  timer_overflow_toggle,
	input wire logic [7:0]  timer_action_routed,
	input wire logic [7:0]  timer_out,
	input wire logic [7:0]  timer_capture_in,
	input wire logic [4:0]  pwm_channel_enable
);
	wire       acc = psel & penable;
	wire [9:0] idx = paddr[11:2];
	// Pin 7 has no PWM, so an active timer always owns it
	wire       tact7 = timer_global_enable & timer_action_routed[7]
		& (timer_compare_select[7] | timer_overflow_toggle[7]);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	pull_out_a: assert property (
		((pin_pull_up | pin_pull_down) & ~pin_oe_n) == 8'h00)
		else $error("pull on driven pin");
	pull_sel_a: assert property (
		(pin_pull_up & pin_pull_down) == 8'h00)
		else $error("pull up and down together");
	drive_in_a: assert property (
		(pin_reduced_drive & pin_oe_n) == 8'h00)
		else $error("reduced drive on input");
	capture_a: assert property ($past(presetn) && $past(presetn, 2)
		|-> timer_capture_in == $past(pin_in, 2)) else $error("capture lag");
	err_gap_a: assert property (acc |->
		pslverr == (idx == 10'h006 || idx > 10'h007)) else $error("slverr");
	rd_upper_a: assert property (
		acc && !pwrite |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	// Data from two edges back: the next setup may already change pwdata
	dir_write_a: assert property (acc && pwrite && idx == 10'h002
		&& !timer_global_enable && pwm_channel_enable == 5'h00
		|-> ##2 pin_oe_n == ~$past(pwdata[7:0], 2))
		else $error("direction lost");
	timer_own_a: assert property ($past(tact7) |-> !pin_oe_n[7]
		&& pin_out[7] == $past(timer_out[7])) else $error("timer not on pin");
	cover property (acc && pslverr);
	cover property (tact7);
	cover property (acc && pwrite && idx == 10'h002);
endmodule
bind ptpc_top ptpc_sva u_ptpc_sva (.*);

// ---- sim/ptpc_top_bench.sv ----
/*
 Self-checking bench of the pin control block over APB.
 Assumes the pin model resolves pad levels back into pin_in.
*/
`include "ptpc_params.svh"
module ptpc_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er;
	logic        timer_global_enable = 1'b0;
	logic [7:0]  timer_compare_select = 8'h00, timer_overflow_toggle = 8'h00;
	logic [7:0]  timer_action_routed = 8'h00, timer_out = 8'h00;
	logic [7:0]  ext = 8'h3c, short_low = 8'h00, timer_capture_in;
	logic [7:0]  pin_in, pin_out, pin_oe_n, pin_reduced_drive;
	logic [7:0]  pin_pull_up, pin_pull_down;
	logic [4:0]  pwm_channel_enable = 5'h00, pwm_out = 5'h00;
	int          n_mismatch = 0, n_compared = 0;
	ptpc_top u_ptpc_top (.*);
	ptpc_pin_model u_ptpc_pin_model (.*);
	initial forever #50 pclk = ~pclk;
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] i,
		input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		// No local limit: only the watchdog ends a hung access
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] i, input logic [7:0] e);
		xfer(1'b0, i, 8'h00);
		check(rd, {24'h0, e});
	endtask
	task automatic final_report;
		if (n_mismatch == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Whole run is about 140 cycles
	initial begin
		#400000;
		n_mismatch++;
		final_report;
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		rd_chk(`PTPC_IDX_DATA, 8'h3c);
		rd_chk(`PTPC_IDX_INPUT, 8'h3c);
		for (int k = 2; k < 8; k++)
			if (k != 6)
				rd_chk(k[7:0], 8'h00);
		xfer(1'b0, 8'h06, 8'h00);
		check(er, 1'b1);
		check(rd, 32'h0000_0000);
		xfer(1'b1, `PTPC_IDX_INPUT, 8'hff);
		rd_chk(`PTPC_IDX_INPUT, 8'h3c);
		xfer(1'b1, `PTPC_IDX_DIR, 8'h0f);
		xfer(1'b1, `PTPC_IDX_DATA, 8'h05);
		xfer(1'b1, `PTPC_IDX_PULLEN, 8'hf0);
		xfer(1'b1, `PTPC_IDX_PULLPOL, 8'h30);
		xfer(1'b1, `PTPC_IDX_DRIVE, 8'hff);
		repeat (4) @(posedge pclk);
		check(pin_pull_up, 8'hc0);
		check(pin_pull_down, 8'h30);
		check(pin_reduced_drive, 8'h0f);
		rd_chk(`PTPC_IDX_DIR, 8'h0f);
		rd_chk(`PTPC_IDX_INPUT, 8'hc5);
		// Overloaded output pin: only the input register may show it
		short_low <= 8'h01;
		repeat (4) @(posedge pclk);
		rd_chk(`PTPC_IDX_INPUT, 8'hc4);
		rd_chk(`PTPC_IDX_DATA, 8'hc5);
		timer_global_enable <= 1'b1;
		timer_compare_select <= 8'h80;
		timer_overflow_toggle <= 8'h40;
		timer_action_routed <= 8'hc0;
		timer_out <= 8'h81;
		repeat (4) @(posedge pclk);
		check(pin_oe_n, 8'h30);
		check(pin_out & 8'hcf, 8'h85);
		check(pin_pull_up, 8'h00);
		rd_chk(`PTPC_IDX_DIR, 8'h0f);
		rd_chk(`PTPC_IDX_INPUT, 8'h84);
		check(timer_capture_in, 8'h84);
		timer_global_enable <= 1'b0;
		repeat (4) @(posedge pclk);
		check(pin_oe_n, 8'hf0);
		timer_compare_select <= 8'h00;
		timer_overflow_toggle <= 8'h00;
		timer_action_routed <= 8'h01;
		timer_out <= 8'h01;
		// Channel 0 low, the rest high: a wrong PWM index shows
		pwm_out <= 5'h1e;
		xfer(1'b1, `PTPC_IDX_DIR, 8'h0e);
		timer_global_enable <= 1'b1;
		// Pin 0: input as GPIO, drives 1 as timer, 0 as PWM
		for (int k = 0; k < 8; k++) begin
			xfer(1'b1, `PTPC_IDX_ROUTE, {7'h0, k[2]});
			pwm_channel_enable <= {4'h0, k[1]};
			timer_compare_select <= {7'h0, k[0]};
			repeat (3) @(posedge pclk);
			check({pin_oe_n[0], pin_out[0] | pin_oe_n[0]},
				(k[2] & k[1]) ? 2'b00 : k[0] ? 2'b01 : 2'b11);
		end
		rd_chk(`PTPC_IDX_ROUTE, 8'h01);
		final_report;
	end
endmodule
